// file: inc/mtcsr_regs.svh
// Purpose: register offsets, fields, reset values of the trap register block
// Assumes: 12-bit register index space, one index per 32-bit register
// Notes:   indexes are used directly as the bus address
// Summary of operation
// - register-file error sources exist only in error-correcting builds.
// - six system external sources exist only in external-interrupt builds.
// - supervisor/user enable and pending aliases read zero; writes only set the alias status bit.
// - direct build: vector base writable, mode writable, resets to direct.
// - vectored build: base is reset vector plus offset, mode is vectored.
// - return address is 32 bits with bit 0 always zero.
// - cause holds interrupt flag bit 31 and five stored code bits.
// - cause clears to zero on hard and soft reset.
// - interrupts record codes 3,7,11,16,17,24-29,30 with flag set.
// - exceptions record codes 0,2,3,4,6,11 with flag clear.
// - custom exceptions record codes 24,25,26,27 for bus/parity errors.
// - concurrent traps taken from software interrupt down to load parity.
// - trap value gets zero for interrupts and environment calls.
// - breakpoints, misaligned fetch, fetch errors store the retiring pc.
// - illegal instruction stores the retiring instruction encoding.
// - misaligned store/load and load errors store the faulting address.
// - time count readable as low and high read-only registers.
// - enable bit positions 3,7,11,16,17,24-29,30; pending matches.
`ifndef MTCSR_REGS_SVH
`define MTCSR_REGS_SVH
`define MTCSR_A_SIE        12'h104
`define MTCSR_A_UIE        12'h004
`define MTCSR_A_SIP        12'h144
`define MTCSR_A_UIP        12'h044
`define MTCSR_A_MIE        12'h304
`define MTCSR_A_TVEC       12'h305
`define MTCSR_A_SCRATCH    12'h340
`define MTCSR_A_EPC        12'h341
`define MTCSR_A_CAUSE      12'h342
`define MTCSR_A_TVAL       12'h343
`define MTCSR_A_MIP        12'h344
`define MTCSR_A_TIME       12'hc01
`define MTCSR_A_TIMEH      12'hc81
`define MTCSR_A_TRAPST     12'h7c0
`define MTCSR_A_TRAPMASK   12'h7c1
`define MTCSR_MODE_DIRECT  2'b00
`define MTCSR_MODE_VECTOR  2'b01
`define MTCSR_CAUSE_RESET  32'h0000_0000
`define MTCSR_IRQ_SW       3
`define MTCSR_IRQ_TMR      7
`define MTCSR_IRQ_EXT      11
`define MTCSR_IRQ_GEU      16
`define MTCSR_IRQ_GEC      17
`define MTCSR_IRQ_SYS0     24
`define MTCSR_IRQ_CUST     30
`define MTCSR_IE_MASK      32'h7f03_0888
`define MTCSR_EX_IMIS      5'h00
`define MTCSR_EX_ILL       5'h02
`define MTCSR_EX_BRK       5'h03
`define MTCSR_EX_LMIS      5'h04
`define MTCSR_EX_SMIS      5'h06
`define MTCSR_EX_ECALL     5'h0b
`define MTCSR_EX_FBUS      5'h18
`define MTCSR_EX_FPAR      5'h19
`define MTCSR_EX_LBUS      5'h1a
`define MTCSR_EX_LPAR      5'h1b
`define MTCSR_ST_TRAP      0
`define MTCSR_ST_IRQ       1
`define MTCSR_ST_ALIAS     2
`endif

// file: inc/mtcsr_pkg.sv
// Purpose: types shared by the trap register block
// Assumes: 32-bit core
// Notes:   exception request bits are in priority order, highest first
package mtcsr_pkg;
  typedef struct packed {
    logic        trig_brk;
    logic        illegal;
    logic        fetch_mis;
    logic        ecall;
    logic        brk;
    logic        store_mis;
    logic        load_mis;
    logic        fetch_bus;
    logic        fetch_par;
    logic        load_bus;
    logic        load_par;
  } mtcsr_exc_s;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] instr;
    logic [31:0] load_addr;
    logic [31:0] store_addr;
  } mtcsr_retire_s;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mtcsr_bus_s;

  typedef enum logic [2:0] {
    MTCSR_IDLE  = 3'b001,
    MTCSR_ENTRY = 3'b010,
    MTCSR_HOLD  = 3'b100
  } mtcsr_state_e;
endpackage

// file: rtl/mtcsr_trap.sv
// Purpose: machine trap registers: vector, scratch, return address, cause,
//          trap value, time aliases, interrupt enable/pending, trap entry
// Assumes: trap requests and retire data come from core logic on mclk;
//          interrupt sources come from pins and are synchronised here
// Notes:   trap_take pulses one cycle; the three trap registers load with it unless soft_rst is high, which clears cause instead
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "mtcsr_regs.svh"
module mtcsr_trap #(
  parameter bit          ECC_EN   = 1'b1,
  parameter bit          SYSEI_EN = 1'b1,
  parameter bit          VECT_EN  = 1'b0,
  parameter logic [31:0] RST_VEC  = 32'h0000_0000,
  parameter logic [31:0] TVEC_OFS = 32'h0000_0000
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   soft_rst,
  input  mtcsr_pkg::mtcsr_bus_s       bus,
  output logic [31:0]                 rdata,
  input  wire logic                   software_irq_source,
  input  wire logic                   timer_irq_source,
  input  wire logic                   external_irq_source,
  input  wire logic                   regfile_uncorrectable_err_irq,
  input  wire logic                   regfile_correctable_err_irq,
  input  wire logic [5:0]             system_external_irq_group,
  input  wire logic                   custom_core_irq,
  input  mtcsr_pkg::mtcsr_exc_s       exc,
  input  mtcsr_pkg::mtcsr_retire_s    retire,
  input  wire logic                   irq_global_en,
  input  wire logic [63:0]            time_count,
  output logic                        trap_take,
  output logic [31:0]                 trap_target,
  output logic [31:0]                 trap_return_address,
  output logic                        irq_out
);
  import mtcsr_pkg::*;

  // ------------------------------------------------------------------
  // reset release and source synchronisers
  // ------------------------------------------------------------------
  logic [1:0]  rst_sync_reg;
  logic        rst_ok;
  logic [31:0] src_raw;
  logic [31:0] src_s1_reg;
  logic [31:0] src_s2_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_reg[1];

  // sources placed at their enable bit positions
  always_comb begin
    src_raw = 32'h0000_0000;
    src_raw[`MTCSR_IRQ_SW]  = software_irq_source;
    src_raw[`MTCSR_IRQ_TMR] = timer_irq_source;
    src_raw[`MTCSR_IRQ_EXT] = external_irq_source;
    src_raw[`MTCSR_IRQ_GEU] = regfile_uncorrectable_err_irq & ECC_EN;
    src_raw[`MTCSR_IRQ_GEC] = regfile_correctable_err_irq & ECC_EN;
    src_raw[29:24] = system_external_irq_group & {6{SYSEI_EN}};
    src_raw[`MTCSR_IRQ_CUST] = custom_core_irq;
  end

  always_ff @(posedge mclk or negedge rst_ok) begin
    if (!rst_ok) begin
      src_s1_reg <= 32'h0000_0000;
      src_s2_reg <= 32'h0000_0000;
    end else begin
      src_s1_reg <= src_raw;
      src_s2_reg <= src_s1_reg;
    end
  end

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  logic [31:0] ie_reg, tvec_reg, scratch_reg, epc_reg, tval_reg;
  logic [31:0] cause_reg, trapst_reg, trapmask_reg;
  logic [31:0] ie_impl, pend, active, tvec_rd, rd_next;
  logic        wr_ie, wr_tvec, wr_scr, wr_epc, wr_cause, wr_tval, wr_mask;
  logic        rd_st, alias_hit;

  assign ie_impl = `MTCSR_IE_MASK
                 & ~({14'h0, ~ECC_EN, ~ECC_EN, 16'h0})
                 & ~({2'b00, {6{~SYSEI_EN}}, 24'h0});
  assign pend    = src_s2_reg & ie_impl;
  assign active  = pend & ie_reg;

  assign wr_ie    = bus.wr && bus.addr == `MTCSR_A_MIE;
  assign wr_tvec  = bus.wr && bus.addr == `MTCSR_A_TVEC;
  assign wr_scr   = bus.wr && bus.addr == `MTCSR_A_SCRATCH;
  assign wr_epc   = bus.wr && bus.addr == `MTCSR_A_EPC;
  assign wr_cause = bus.wr && bus.addr == `MTCSR_A_CAUSE;
  assign wr_tval  = bus.wr && bus.addr == `MTCSR_A_TVAL;
  assign wr_mask  = bus.wr && bus.addr == `MTCSR_A_TRAPMASK;
  assign rd_st    = bus.rd && bus.addr == `MTCSR_A_TRAPST;
  assign alias_hit = (bus.rd | bus.wr) &&
                     (bus.addr == `MTCSR_A_SIE || bus.addr == `MTCSR_A_UIE ||
                      bus.addr == `MTCSR_A_SIP ||
                      bus.addr == `MTCSR_A_UIP);

  assign tvec_rd = VECT_EN ? {RST_VEC[31:2] + TVEC_OFS[31:2],
                              `MTCSR_MODE_VECTOR}
                           : tvec_reg;

  // ------------------------------------------------------------------
  // trap selection in priority order
  // ------------------------------------------------------------------
  logic        irq_req, exc_any;
  logic [4:0]  irq_code, exc_code;
  logic [31:0] exc_val, sel_val;
  logic [31:0] sel_cause;

  always_comb begin
    irq_code = 5'h00;
    // scan from bit 30 down so the lowest set bit wins
    for (int i = 30; i >= 0; i--) begin
      if (active[i]) begin
        irq_code = 5'(i);
      end
    end
    if (active[`MTCSR_IRQ_SW]) begin
      irq_code = 5'(`MTCSR_IRQ_SW);
    end else if (active[`MTCSR_IRQ_TMR]) begin
      irq_code = 5'(`MTCSR_IRQ_TMR);
    end else if (active[`MTCSR_IRQ_EXT]) begin
      irq_code = 5'(`MTCSR_IRQ_EXT);
    end
  end
  assign irq_req = irq_global_en && (active != 32'h0);
  assign exc_any = exc != '0;

  always_comb begin
    exc_code = `MTCSR_EX_LPAR;
    exc_val  = retire.load_addr;
    if (exc.trig_brk) begin
      exc_code = `MTCSR_EX_BRK;
      exc_val  = retire.pc;
    end else if (exc.illegal) begin
      exc_code = `MTCSR_EX_ILL;
      exc_val  = retire.instr;
    end else if (exc.fetch_mis) begin
      exc_code = `MTCSR_EX_IMIS;
      exc_val  = retire.pc;
    end else if (exc.ecall) begin
      exc_code = `MTCSR_EX_ECALL;
      exc_val  = 32'h0000_0000;
    end else if (exc.brk) begin
      exc_code = `MTCSR_EX_BRK;
      exc_val  = retire.pc;
    end else if (exc.store_mis) begin
      exc_code = `MTCSR_EX_SMIS;
      exc_val  = retire.store_addr;
    end else if (exc.load_mis) begin
      exc_code = `MTCSR_EX_LMIS;
    end else if (exc.fetch_bus) begin
      exc_code = `MTCSR_EX_FBUS;
      exc_val  = retire.pc;
    end else if (exc.fetch_par) begin
      exc_code = `MTCSR_EX_FPAR;
      exc_val  = retire.pc;
    end else if (exc.load_bus) begin
      exc_code = `MTCSR_EX_LBUS;
    end
  end

  // interrupts outrank exceptions
  assign sel_cause = irq_req ? {1'b1, 26'h0, irq_code}
                             : {1'b0, 26'h0, exc_code};
  assign sel_val   = irq_req ? 32'h0000_0000 : exc_val;

  // ------------------------------------------------------------------
  // trap entry state machine
  // ------------------------------------------------------------------
  mtcsr_state_e st_reg, st_next;
  logic         take;

  assign take = st_reg == MTCSR_IDLE && (irq_req || exc_any);
  always_comb begin
    case (st_reg)
      MTCSR_IDLE:  st_next = take ? MTCSR_ENTRY : MTCSR_IDLE;
      MTCSR_ENTRY: st_next = MTCSR_HOLD;
      MTCSR_HOLD:  st_next = MTCSR_IDLE;
      default:     st_next = MTCSR_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [31:0] st_set;
  assign st_set = {29'h0, alias_hit & bus.wr, irq_req & take, take};

  always_ff @(posedge mclk or negedge rst_ok) begin
    if (!rst_ok) begin
      st_reg       <= MTCSR_IDLE;
      ie_reg       <= 32'h0000_0000;
      tvec_reg     <= {30'h0, `MTCSR_MODE_DIRECT};
      scratch_reg  <= 32'h0000_0000;
      epc_reg      <= 32'h0000_0000;
      tval_reg     <= 32'h0000_0000;
      cause_reg    <= `MTCSR_CAUSE_RESET;
      trapst_reg   <= 32'h0000_0000;
      trapmask_reg <= 32'h0000_0000;
      rdata        <= 32'h0000_0000;
      trap_take    <= 1'b0;
      trap_target  <= 32'h0000_0000;
      irq_out      <= 1'b0;
    end else begin
      st_reg      <= st_next;
      trap_take   <= take;
      irq_out     <= (trapst_reg & trapmask_reg) != 32'h0;
      rdata       <= rd_next;
      trapst_reg  <= ((rd_st ? 32'h0 : trapst_reg) | st_set) & 32'h7;
      if (wr_mask) trapmask_reg <= bus.wdata & 32'h7;
      if (wr_ie) ie_reg <= bus.wdata & ie_impl;
      if (wr_tvec && !VECT_EN) tvec_reg <= bus.wdata;
      if (wr_scr) scratch_reg <= bus.wdata;
      if (soft_rst) begin
        cause_reg <= `MTCSR_CAUSE_RESET;
      end else if (take) begin
        cause_reg   <= sel_cause;
        epc_reg     <= {retire.pc[31:1], 1'b0};
        tval_reg    <= sel_val;
        trap_target <= (VECT_EN && irq_req) ?
                       {tvec_rd[31:2], 2'b00} + {25'h0, irq_code, 2'b00} :
                       {tvec_rd[31:2], 2'b00};
      end else begin
        if (wr_cause) cause_reg <= {bus.wdata[31], 26'h0,
                                    bus.wdata[4:0]};
        if (wr_epc) epc_reg <= {bus.wdata[31:1], 1'b0};
        if (wr_tval) tval_reg <= bus.wdata;
      end
    end
  end
  assign trap_return_address = epc_reg;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_next = 32'h0000_0000; // aliases and unmapped read zero
    if (bus.rd) begin
      case (bus.addr)
        `MTCSR_A_MIE:      rd_next = ie_reg;
        `MTCSR_A_MIP:      rd_next = pend;
        `MTCSR_A_TVEC:     rd_next = tvec_rd;
        `MTCSR_A_SCRATCH:  rd_next = scratch_reg;
        `MTCSR_A_EPC:      rd_next = epc_reg;
        `MTCSR_A_CAUSE:    rd_next = cause_reg;
        `MTCSR_A_TVAL:     rd_next = tval_reg;
        `MTCSR_A_TIME:     rd_next = time_count[31:0];
        `MTCSR_A_TIMEH:    rd_next = time_count[63:32];
        `MTCSR_A_TRAPST:   rd_next = trapst_reg;
        `MTCSR_A_TRAPMASK: rd_next = trapmask_reg;
        default:           rd_next = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_cause_code;
    @(posedge mclk) disable iff (!rst_ok)
      (take && !soft_rst) |=> cause_reg == $past(sel_cause);
  endproperty
  a_cause_code: assert property (p_cause_code)
    else $error("cause not loaded on trap");

  property p_cause_bits;
    @(posedge mclk) disable iff (!rst_ok)
      cause_reg[30:5] == 26'h0;
  endproperty
  a_cause_bits: assert property (p_cause_bits)
    else $error("cause upper code bits set");

  property p_soft;
    @(posedge mclk) disable iff (!rst_ok)
      soft_rst |=> cause_reg == 32'h0;
  endproperty
  a_soft: assert property (p_soft)
    else $error("cause not cleared by soft reset");

  property p_epc0;
    @(posedge mclk) disable iff (!rst_ok)
      epc_reg[0] == 1'b0;
  endproperty
  a_epc0: assert property (p_epc0)
    else $error("return address bit 0 set");

  property p_irq_tval;
    @(posedge mclk) disable iff (!rst_ok)
      (take && irq_req && !soft_rst) |=> tval_reg == 32'h0 && cause_reg[31];
  endproperty
  a_irq_tval: assert property (p_irq_tval)
    else $error("interrupt trap value not zero");

  property p_ill;
    @(posedge mclk) disable iff (!rst_ok)
      (take && !irq_req && exc.illegal && !exc.trig_brk && !soft_rst)
        |=> tval_reg == $past(retire.instr) && cause_reg == 32'h2;
  endproperty
  a_ill: assert property (p_ill)
    else $error("illegal instruction trap wrong");

  property p_sw_first;
    @(posedge mclk) disable iff (!rst_ok)
      (take && active[`MTCSR_IRQ_SW] && irq_req && !soft_rst)
        |=> cause_reg == 32'h8000_0003;
  endproperty
  a_sw_first: assert property (p_sw_first)
    else $error("software interrupt not highest");

  property p_alias;
    @(posedge mclk) disable iff (!rst_ok)
      (bus.rd && alias_hit) |=> rdata == 32'h0;
  endproperty
  a_alias: assert property (p_alias)
    else $error("alias read not zero");

  property p_time;
    @(posedge mclk) disable iff (!rst_ok)
      (bus.rd && bus.addr == `MTCSR_A_TIMEH)
        |=> rdata == $past(time_count[63:32]);
  endproperty
  a_time: assert property (p_time)
    else $error("time high read wrong");

  property p_store_tval;
    @(posedge mclk) disable iff (!rst_ok)
      (take && !irq_req && !soft_rst && exc[10:5] == 6'h01)
        |=> tval_reg == $past(retire.store_addr) && cause_reg == 32'h6;
  endproperty
  a_store_tval: assert property (p_store_tval)
    else $error("misaligned store trap wrong");

  property p_fetch_bus;
    @(posedge mclk) disable iff (!rst_ok)
      (take && !irq_req && !soft_rst && exc[10:3] == 8'h01)
        |=> tval_reg == $past(retire.pc) && cause_reg == 32'h18;
  endproperty
  a_fetch_bus: assert property (p_fetch_bus)
    else $error("fetch bus error trap wrong");
endmodule // mtcsr_trap

// file: tb/testbench.sv
// Purpose: self-checking bench for the machine trap register block
// Assumes: default build plus a vectored build without optional sources
// Notes:   a bench model of the registers is compared at every read
`timescale 1ns/1ps
`include "mtcsr_regs.svh"
module testbench;
  import mtcsr_pkg::*;
  // ----------------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------------
  logic          mclk, rst_n, soft_rst, irq_global_en;
  mtcsr_bus_s    bus;
  mtcsr_exc_s    exc;
  mtcsr_retire_s retire;
  logic [11:0]   irq_src;
  logic [63:0]   time_count;
  logic [31:0]   rdata, rdata_vec, trap_target, trap_return_address, alt;
  logic          trap_take, irq_out;
  logic [31:0]   tgt_vec;
  int            num_errors, compares;
  logic [31:0]   mreg [logic [11:0]];
  int exc_code [11] = '{27, 26, 25, 24, 4, 6, 3, 11, 0, 2, 3};
  int exc_tv   [11] = '{1, 1, 0, 0, 1, 2, 0, 3, 0, 4, 0};
  int irq_code [12] = '{3, 7, 11, 16, 17, 24, 25, 26, 27, 28, 29, 30};
  logic [11:0] alias_a [4] = '{`MTCSR_A_SIE, `MTCSR_A_UIE, `MTCSR_A_SIP,
                               `MTCSR_A_UIP};

  mtcsr_trap i_mtcsr_trap (
    .mclk(mclk), .rst_n(rst_n), .soft_rst(soft_rst), .bus(bus),
    .rdata(rdata), .software_irq_source(irq_src[0]),
    .timer_irq_source(irq_src[1]), .external_irq_source(irq_src[2]),
    .regfile_uncorrectable_err_irq(irq_src[3]),
    .regfile_correctable_err_irq(irq_src[4]),
    .system_external_irq_group(irq_src[10:5]),
    .custom_core_irq(irq_src[11]), .exc(exc), .retire(retire),
    .irq_global_en(irq_global_en), .time_count(time_count),
    .trap_take(trap_take), .trap_target(trap_target),
    .trap_return_address(trap_return_address), .irq_out(irq_out));

  // vectored build without error-correction or system sources
  mtcsr_trap #(.ECC_EN(1'b0), .SYSEI_EN(1'b0), .VECT_EN(1'b1),
    .RST_VEC(32'h0000_2000), .TVEC_OFS(32'h0000_0100)) i_mtcsr_trap_vec (
    .mclk(mclk), .rst_n(rst_n), .soft_rst(soft_rst), .bus(bus),
    .rdata(rdata_vec), .software_irq_source(irq_src[0]),
    .timer_irq_source(irq_src[1]), .external_irq_source(irq_src[2]),
    .regfile_uncorrectable_err_irq(irq_src[3]),
    .regfile_correctable_err_irq(irq_src[4]),
    .system_external_irq_group(irq_src[10:5]),
    .custom_core_irq(irq_src[11]), .exc(exc), .retire(retire),
    .irq_global_en(irq_global_en), .time_count(time_count),
    .trap_take(), .trap_target(tgt_vec), .trap_return_address(), .irq_out());

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    mreg.delete();
    mreg[`MTCSR_A_TVEC] = 32'h0;
    mreg[`MTCSR_A_TRAPST] = 32'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    case (a)
      `MTCSR_A_SCRATCH, `MTCSR_A_TVAL, `MTCSR_A_TVEC: mreg[a] = v;
      `MTCSR_A_EPC:      mreg[a] = v & 32'hffff_fffe;
      `MTCSR_A_CAUSE:    mreg[a] = v & 32'h8000_001f;
      `MTCSR_A_MIE:      mreg[a] = v & `MTCSR_IE_MASK;
      `MTCSR_A_TRAPMASK: mreg[a] = v & 32'h0000_0007;
      `MTCSR_A_SIE, `MTCSR_A_UIE, `MTCSR_A_SIP, `MTCSR_A_UIP:
        mreg[`MTCSR_A_TRAPST] |= 32'h0000_0004;
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [11:0] a);
    logic [31:0] e;
    e = mreg.exists(a) ? mreg[a] : 32'h0;
    if (a == `MTCSR_A_TIME) e = time_count[31:0];
    if (a == `MTCSR_A_TIMEH) e = time_count[63:32];
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    alt = rdata_vec;
    check(rdata, e);
    if (a == `MTCSR_A_TRAPST) mreg[a] = 32'h0;
  endtask

  task automatic wait_trap();
    int n;
    n = 0;
    #1;
    while (trap_take !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (trap_take !== 1'b1) begin
      check(trap_take, 1'b1);
      end_of_test();
    end
  endtask

  task automatic trap_check(input logic [31:0] c, input logic [31:0] tv);
    wait_trap();
    check(trap_return_address, retire.pc & 32'hffff_fffe);
    check(trap_target, {mreg[`MTCSR_A_TVEC][31:2], 2'b00});
    @(posedge mclk);
    irq_global_en <= 1'b0;
    irq_src <= '0;
    mreg[`MTCSR_A_CAUSE] = c;
    mreg[`MTCSR_A_TVAL] = tv;
    mreg[`MTCSR_A_EPC] = retire.pc & 32'hffff_fffe;
    mreg[`MTCSR_A_TRAPST] |= c[31] ? 32'h3 : 32'h1;
    rd_chk(`MTCSR_A_CAUSE);
    rd_chk(`MTCSR_A_TVAL);
    rd_chk(`MTCSR_A_EPC);
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] tv;
    rst_n = 1'b0; soft_rst = 1'b0; irq_global_en = 1'b0; bus = '0;
    exc = '0; retire = '0; irq_src = '0; time_count = '0;
    num_errors = 0; compares = 0;
    void'($urandom(55931));
    do_reset();
    rd_chk(`MTCSR_A_CAUSE);
    rd_chk(`MTCSR_A_TVEC);
    repeat (3) begin
      wr(`MTCSR_A_SCRATCH, $urandom); rd_chk(`MTCSR_A_SCRATCH);
      wr(`MTCSR_A_EPC, $urandom); rd_chk(`MTCSR_A_EPC);
      wr(`MTCSR_A_CAUSE, $urandom); rd_chk(`MTCSR_A_CAUSE);
      wr(`MTCSR_A_TVAL, $urandom); rd_chk(`MTCSR_A_TVAL);
      wr(`MTCSR_A_TVEC, $urandom & 32'hffff_fffd);
      rd_chk(`MTCSR_A_TVEC);
      check(alt, 32'h0000_2101);
      time_count <= {$urandom, $urandom};
      wr(`MTCSR_A_TIME, $urandom);
      rd_chk(`MTCSR_A_TIME);
      rd_chk(`MTCSR_A_TIMEH);
    end
    for (int i = 0; i < 4; i++) begin
      wr(alias_a[i], 32'hffff_ffff);
      rd_chk(alias_a[i]);
    end
    wr(12'h7ff, 32'hffff_ffff); rd_chk(12'h7ff);
    rd_chk(`MTCSR_A_TRAPST);
    wr(`MTCSR_A_MIE, 32'hffff_ffff);
    rd_chk(`MTCSR_A_MIE);
    check(alt, 32'h4000_0888);
    $display("register access test done");
    wr(`MTCSR_A_TRAPMASK, 32'h1);
    for (int i = 10; i >= 0; i--) begin
      @(posedge mclk);
      retire <= {$urandom, $urandom, $urandom, $urandom};
      exc <= mtcsr_exc_s'(11'((1 << (i + 1)) - 1));
      @(posedge mclk);
      exc <= '0;
      #1;
      case (exc_tv[i])
        0: tv = retire.pc;
        1: tv = retire.load_addr;
        2: tv = retire.store_addr;
        3: tv = 32'h0;
        default: tv = retire.instr;
      endcase
      trap_check(32'(exc_code[i]), tv);
    end
    repeat (2) @(posedge mclk);
    #1 check(irq_out, 1'b1);
    rd_chk(`MTCSR_A_TRAPST);
    repeat (3) @(posedge mclk);
    #1 check(irq_out, 1'b0);
    $display("exception priority test done");
    wr(`MTCSR_A_TRAPMASK, 32'h0);
    for (int k = 0; k < 12; k++) begin
      @(posedge mclk);
      retire <= {$urandom, $urandom, $urandom, $urandom};
      irq_global_en <= 1'b1;
      irq_src <= 12'hfff << k;
      trap_check(32'h8000_0000 | 32'(irq_code[k]), 32'h0);
      tv = 32'h0000_2100 + 32'(4 * (k < 3 ? irq_code[k] : 30));
      check(tgt_vec, tv);
    end
    #1 check(irq_out, 1'b0);
    rd_chk(`MTCSR_A_TRAPST);
    @(posedge mclk);
    irq_src <= 12'hfff;
    repeat (3) @(posedge mclk);
    mreg[`MTCSR_A_MIP] = `MTCSR_IE_MASK;
    rd_chk(`MTCSR_A_MIP);
    check(alt, 32'h4000_0888);
    irq_src <= '0;
    mreg[`MTCSR_A_MIP] = 32'h0;
    $display("interrupt priority test done");
    wr(`MTCSR_A_CAUSE, 32'h8000_001f);
    @(posedge mclk);
    soft_rst <= 1'b1;
    @(posedge mclk);
    soft_rst <= 1'b0;
    mreg[`MTCSR_A_CAUSE] = 32'h0;
    rd_chk(`MTCSR_A_CAUSE);
    wr(`MTCSR_A_CAUSE, 32'h8000_0011);
    do_reset();
    rd_chk(`MTCSR_A_CAUSE);
    rd_chk(`MTCSR_A_TVEC);
    $display("reset test done");
    end_of_test();
  end
endmodule // testbench
